// ==== dtbcc_asserts.sv ====
// Port-level checks for the converter control block
`timescale 1ns/1ps
module dtbcc_asserts #(
  parameter int NCH = 4
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic AVS_WRITE,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic [NCH*10-1:0] ACTIVE_CODE,
  input wire logic [NCH*10-1:0] INTERNAL_CODE,
  input wire logic [NCH-1:0] CONVERTER_ENABLE,
  input wire logic [NCH-1:0] ANALOG_OUT_PIN_ONE,
  input wire logic [NCH-1:0] ANALOG_OUT_PIN_TWO,
  input wire logic [NCH-1:0] PIN_ONE_DRIVE_OE,
  input wire logic [NCH-1:0] PIN_TWO_INPUT_EN,
  input wire logic [NCH*2-1:0] POSITIVE_SOURCE_SELECT,
  input wire logic [NCH*2-1:0] NEGATIVE_SOURCE_SELECT,
  input wire logic [NCH-1:0] SOURCE_VALID
);
  logic [2:0] ld_age_q;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  // Active code may only move a few cycles after a load write
  always_ff @(posedge CLK_SYS) begin
    if (SRST) ld_age_q <= 3'h7;
    else if (AVS_WRITE && AVS_ADDRESS[3:0] == 4'h3) ld_age_q <= 3'h0;
    else if (ld_age_q != 3'h7) ld_age_q <= ld_age_q + 3'h1;
  end
  route_one_a: assert property (!(|(ANALOG_OUT_PIN_ONE & PIN_ONE_DRIVE_OE)))
    else $error("pin one driven while routed");
  route_two_a: assert property (!(|(ANALOG_OUT_PIN_TWO & PIN_TWO_INPUT_EN)))
    else $error("pin two input on while routed");
  pin_gate_a: assert property (!(|((ANALOG_OUT_PIN_ONE | ANALOG_OUT_PIN_TWO) & ~CONVERTER_ENABLE)))
    else $error("analog pin on while disabled");
  rst_clear_a: assert property ($fell(SRST) |-> ACTIVE_CODE == '0 && CONVERTER_ENABLE == '0)
    else $error("state not cleared by reset");
  internal_a: assert property (INTERNAL_CODE == ACTIVE_CODE)
    else $error("internal code differs");
  code_hold_a: assert property (!$stable(ACTIVE_CODE) && !$past(SRST) |-> ld_age_q <= 3'h5)
    else $error("active code moved without load");
  pos_rsvd_a: assert property (POSITIVE_SOURCE_SELECT[1:0] == 2'h3 |-> !SOURCE_VALID[0])
    else $error("reserved positive source valid");
  neg_rsvd_a: assert property (NEGATIVE_SOURCE_SELECT[1:0] == 2'h3 |-> !SOURCE_VALID[0])
    else $error("reserved negative source valid");
endmodule : dtbcc_asserts
bind dtbcc_top dtbcc_asserts #(.NCH(NCH)) dtbcc_asserts_i (.CLK_SYS(CLK_SYS), .SRST(SRST),
  .AVS_WRITE(AVS_WRITE), .AVS_ADDRESS(AVS_ADDRESS), .ACTIVE_CODE(ACTIVE_CODE),
  .INTERNAL_CODE(INTERNAL_CODE), .CONVERTER_ENABLE(CONVERTER_ENABLE),
  .ANALOG_OUT_PIN_ONE(ANALOG_OUT_PIN_ONE), .ANALOG_OUT_PIN_TWO(ANALOG_OUT_PIN_TWO),
  .PIN_ONE_DRIVE_OE(PIN_ONE_DRIVE_OE), .PIN_TWO_INPUT_EN(PIN_TWO_INPUT_EN),
  .POSITIVE_SOURCE_SELECT(POSITIVE_SOURCE_SELECT),
  .NEGATIVE_SOURCE_SELECT(NEGATIVE_SOURCE_SELECT), .SOURCE_VALID(SOURCE_VALID));

// ==== dtbcc_channel.sv ====
// One converter instance: control byte, code bytes and active code buffer
`timescale 1ns/1ps
`include "dtbcc_consts.svh"
module dtbcc_channel
  import dtbcc_pkg::*;
#(
  parameter bit HAS_EXT1 = 1'b0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic wr_ctrl,
  input wire logic wr_hi,
  input wire logic wr_lo,
  input wire logic [7:0] wdata,
  input wire logic load,
  output logic [7:0] ctrl_q,
  output logic [7:0] hi_rd,
  output logic [7:0] lo_rd,
  output logic [9:0] code_q,
  output logic src_valid
);
  logic [9:0] stage_q;
  logic fm;
  dtbcc_pss_t pss;
  dtbcc_nss_t nss;

  assign fm = ctrl_q[`DTBCC_BIT_FM];
  assign pss = dtbcc_pss_t'(ctrl_q[`DTBCC_PSS_HI:`DTBCC_PSS_LO]);
  assign nss = dtbcc_nss_t'(ctrl_q[`DTBCC_NSS_HI:`DTBCC_NSS_LO]);

  // Sleep wake has no path here, so only reset and control writes touch the byte
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `DTBCC_CTRL_RST;
    end else if (ce && wr_ctrl) begin
      ctrl_q <= wdata;
    end
  end

  // Staged code is kept as 10 bits; the byte views depend on the format
  always_ff @(posedge clk) begin
    if (srst) begin
      stage_q <= `DTBCC_CODE_RST;
    end else if (ce) begin
      if (wr_hi) begin
        if (fm) begin
          stage_q[9:2] <= wdata;
        end else begin
          stage_q[9:8] <= wdata[1:0];
        end
      end
      if (wr_lo) begin
        if (fm) begin
          stage_q[1:0] <= wdata[7:6];
        end else begin
          stage_q[7:0] <= wdata;
        end
      end
    end
  end

  // Staged writes never reach the converter until a load
  always_ff @(posedge clk) begin
    if (srst) begin
      code_q <= `DTBCC_CODE_RST;
    end else if (ce && load) begin
      code_q <= stage_q;
    end
  end

  always_comb begin
    if (fm) begin
      hi_rd = stage_q[9:2];
      lo_rd = {stage_q[1:0], 6'h00};
    end else begin
      hi_rd = {6'h00, stage_q[9:8]};
      lo_rd = stage_q[7:0];
    end
  end

  // Reserved source codes flag an unusable ladder configuration
  always_comb begin
    src_valid = 1'b1;
    case (pss)
      DTBCC_PSS_EXT1: src_valid = HAS_EXT1;
      default: src_valid = 1'b1;
    endcase
    case (nss)
      DTBCC_NSS_EXT1: src_valid = src_valid & HAS_EXT1;
      DTBCC_NSS_RSVD: src_valid = 1'b0;
      default: src_valid = src_valid;
    endcase
  end
endmodule : dtbcc_channel

// ==== dtbcc_consts.svh ====
// Register offsets, field positions, reset values and the load mask
`ifndef DTBCC_CONSTS_SVH
`define DTBCC_CONSTS_SVH
`define DTBCC_ADDR_W 4
`define DTBCC_OFS_CTRL 4'h0
`define DTBCC_OFS_CODE_HI 4'h1
`define DTBCC_OFS_CODE_LO 4'h2
`define DTBCC_OFS_LOAD 4'h3
`define DTBCC_OFS_STATUS 4'h4
`define DTBCC_OFS_PIN_IN 4'h5
`define DTBCC_BIT_EN 7
`define DTBCC_BIT_FM 6
`define DTBCC_BIT_OE1 5
`define DTBCC_BIT_OE2 4
`define DTBCC_PSS_HI 3
`define DTBCC_PSS_LO 2
`define DTBCC_NSS_HI 1
`define DTBCC_NSS_LO 0
`define DTBCC_CTRL_RST 8'h00
`define DTBCC_CODE_RST 10'h000
`define DTBCC_LOAD_MASK 8'h33
`define DTBCC_CODE_W 10
`endif

// ==== dtbcc_pkg.sv ====
// Types shared by the converter control block
package dtbcc_pkg;
  typedef enum logic [1:0] {
    DTBCC_PSS_SUPPLY,
    DTBCC_PSS_EXT0,
    DTBCC_PSS_FIXED,
    DTBCC_PSS_EXT1
  } dtbcc_pss_t;
  typedef enum logic [1:0] {
    DTBCC_NSS_GND,
    DTBCC_NSS_EXT0,
    DTBCC_NSS_EXT1,
    DTBCC_NSS_RSVD
  } dtbcc_nss_t;
  typedef enum logic [1:0] {
    DTBCC_BUS_IDLE,
    DTBCC_BUS_ACK
  } dtbcc_bus_t;
endpackage : dtbcc_pkg

// ==== dtbcc_top.sv ====
// Avalon-MM register block controlling four 10-bit converter instances
// Overview of operation
// - Hold a 10-bit code, 1024 levels
// - Converter runs only while bit 7 set
// - Bit 6 picks left or right justification
// - Left: high byte 9:2, low 7:6
// - Right: low byte 7:0, high 1:0
// - Code byte writes do not change output
// - Load bit copies all ten bits together
// - Bit 5 routes voltage to pin one
// - Bit 4 routes voltage to pin two
// - Routed pin loses digital drive and input
// - Routed pin reads as zero digitally
// - Positive source decode, ext1 on 2/3 only
// - Negative source decode, 11 reserved
// - Sleep wake keeps control byte unchanged
// - Reset disables, removes pins, clears code
// - Internal consumers always see the voltage
// - Self-clearing load bits 0,1,4,5 per instance
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`include "dtbcc_consts.svh"
module dtbcc_top
  import dtbcc_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic CLK_SYS,
  input wire logic SRST,
  input wire logic CE,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [NCH-1:0] PIN_ONE_IN,
  input wire logic [NCH-1:0] PIN_TWO_IN,
  input wire logic [NCH-1:0] PIN_ONE_DIG_OE,
  input wire logic [NCH-1:0] PIN_TWO_DIG_OE,
  output logic [NCH*10-1:0] ACTIVE_CODE,
  output logic [NCH*10-1:0] INTERNAL_CODE,
  output logic [NCH-1:0] CONVERTER_ENABLE,
  output logic [NCH-1:0] ANALOG_OUT_PIN_ONE,
  output logic [NCH-1:0] ANALOG_OUT_PIN_TWO,
  output logic [NCH-1:0] PIN_ONE_DRIVE_OE,
  output logic [NCH-1:0] PIN_TWO_DRIVE_OE,
  output logic [NCH-1:0] PIN_ONE_INPUT_EN,
  output logic [NCH-1:0] PIN_TWO_INPUT_EN,
  output logic [NCH*2-1:0] POSITIVE_SOURCE_SELECT,
  output logic [NCH*2-1:0] NEGATIVE_SOURCE_SELECT,
  output logic [NCH-1:0] SOURCE_VALID
);
  // Load bit position of each instance in the shared transfer register
  localparam int LOAD_POS [4] = '{0, 1, 4, 5};

  dtbcc_bus_t bus_q;
  logic [`DTBCC_ADDR_W-1:0] reg_ofs;
  logic [1:0] ch_sel;
  logic acc_wr;
  logic acc_rd;
  logic [7:0] wbyte;
  logic [7:0] load_q;
  logic [NCH-1:0] load_pulse;
  logic [NCH-1:0] p1_s1_q;
  logic [NCH-1:0] p1_s2_q;
  logic [NCH-1:0] p2_s1_q;
  logic [NCH-1:0] p2_s2_q;
  logic [7:0] ctrl_w [NCH];
  logic [7:0] hi_w [NCH];
  logic [7:0] lo_w [NCH];
  logic [9:0] code_w [NCH];
  logic [NCH-1:0] srcv_w;
  logic [7:0] rd_byte;
  logic [7:0] pin_rd;
  logic rd_hit;

  // Channel number in the upper address bits, register in the lower four
  assign reg_ofs = AVS_ADDRESS[3:0];
  assign ch_sel = AVS_ADDRESS[5:4];
  assign wbyte = AVS_WRITEDATA[7:0];

  // Accesses complete in the cycle after they appear
  assign acc_wr = CE && AVS_WRITE && (bus_q == DTBCC_BUS_IDLE) && AVS_BYTEENABLE[0];
  assign acc_rd = CE && AVS_READ && (bus_q == DTBCC_BUS_IDLE);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      bus_q <= DTBCC_BUS_IDLE;
    end else if (CE) begin
      case (bus_q)
        DTBCC_BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_q <= DTBCC_BUS_ACK;
          end
        end
        DTBCC_BUS_ACK: bus_q <= DTBCC_BUS_IDLE;
        default: bus_q <= DTBCC_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if (CE) begin
      AVS_WAITREQUEST <= !((bus_q == DTBCC_BUS_IDLE) && (AVS_READ || AVS_WRITE));
    end
  end

  // Load bits clear the cycle after the transfer, so they read back as zero
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      load_q <= 8'h00;
    end else if (CE) begin
      if (acc_wr && reg_ofs == `DTBCC_OFS_LOAD) begin
        load_q <= wbyte & `DTBCC_LOAD_MASK;
      end else begin
        load_q <= 8'h00;
      end
    end
  end

  // Digital pin inputs come from outside, two stages before use
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      p1_s1_q <= '0;
      p1_s2_q <= '0;
      p2_s1_q <= '0;
      p2_s2_q <= '0;
    end else if (CE) begin
      p1_s1_q <= PIN_ONE_IN;
      p1_s2_q <= p1_s1_q;
      p2_s1_q <= PIN_TWO_IN;
      p2_s2_q <= p2_s1_q;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic sel;
    assign sel = (ch_sel == 2'(i));
    assign load_pulse[i] = load_q[LOAD_POS[i]];
    dtbcc_channel #(
      .HAS_EXT1(i >= 2)
    ) u_ch (
      .clk(CLK_SYS),
      .srst(SRST),
      .ce(CE),
      .wr_ctrl(acc_wr && sel && reg_ofs == `DTBCC_OFS_CTRL),
      .wr_hi(acc_wr && sel && reg_ofs == `DTBCC_OFS_CODE_HI),
      .wr_lo(acc_wr && sel && reg_ofs == `DTBCC_OFS_CODE_LO),
      .wdata(wbyte),
      .load(load_pulse[i]),
      .ctrl_q(ctrl_w[i]),
      .hi_rd(hi_w[i]),
      .lo_rd(lo_w[i]),
      .code_q(code_w[i]),
      .src_valid(srcv_w[i])
    );

    always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
        ACTIVE_CODE[i*10 +: 10] <= `DTBCC_CODE_RST;
        INTERNAL_CODE[i*10 +: 10] <= `DTBCC_CODE_RST;
        CONVERTER_ENABLE[i] <= 1'b0;
        ANALOG_OUT_PIN_ONE[i] <= 1'b0;
        ANALOG_OUT_PIN_TWO[i] <= 1'b0;
        PIN_ONE_DRIVE_OE[i] <= 1'b0;
        PIN_TWO_DRIVE_OE[i] <= 1'b0;
        PIN_ONE_INPUT_EN[i] <= 1'b0;
        PIN_TWO_INPUT_EN[i] <= 1'b0;
        POSITIVE_SOURCE_SELECT[i*2 +: 2] <= 2'h0;
        NEGATIVE_SOURCE_SELECT[i*2 +: 2] <= 2'h0;
        SOURCE_VALID[i] <= 1'b1;
      end else if (CE) begin
        ACTIVE_CODE[i*10 +: 10] <= code_w[i];
        // Internal consumers are fed regardless of pin routing
        INTERNAL_CODE[i*10 +: 10] <= code_w[i];
        CONVERTER_ENABLE[i] <= ctrl_w[i][`DTBCC_BIT_EN];
        ANALOG_OUT_PIN_ONE[i] <= ctrl_w[i][`DTBCC_BIT_EN] & ctrl_w[i][`DTBCC_BIT_OE1];
        ANALOG_OUT_PIN_TWO[i] <= ctrl_w[i][`DTBCC_BIT_EN] & ctrl_w[i][`DTBCC_BIT_OE2];
        PIN_ONE_DRIVE_OE[i] <= PIN_ONE_DIG_OE[i] & ~ctrl_w[i][`DTBCC_BIT_OE1];
        PIN_TWO_DRIVE_OE[i] <= PIN_TWO_DIG_OE[i] & ~ctrl_w[i][`DTBCC_BIT_OE2];
        PIN_ONE_INPUT_EN[i] <= ~ctrl_w[i][`DTBCC_BIT_OE1];
        PIN_TWO_INPUT_EN[i] <= ~ctrl_w[i][`DTBCC_BIT_OE2];
        POSITIVE_SOURCE_SELECT[i*2 +: 2] <= ctrl_w[i][`DTBCC_PSS_HI:`DTBCC_PSS_LO];
        NEGATIVE_SOURCE_SELECT[i*2 +: 2] <= ctrl_w[i][`DTBCC_NSS_HI:`DTBCC_NSS_LO];
        SOURCE_VALID[i] <= srcv_w[i];
      end
    end
  end

  // Pin read: bit 0 pin one, bit 1 pin two, zero when routed to analog
  always_comb begin
    pin_rd = 8'h00;
    pin_rd[0] = p1_s2_q[ch_sel] & ~ctrl_w[ch_sel][`DTBCC_BIT_OE1];
    pin_rd[1] = p2_s2_q[ch_sel] & ~ctrl_w[ch_sel][`DTBCC_BIT_OE2];
  end

  always_comb begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    case (reg_ofs)
      `DTBCC_OFS_CTRL: rd_byte = ctrl_w[ch_sel];
      `DTBCC_OFS_CODE_HI: rd_byte = hi_w[ch_sel];
      `DTBCC_OFS_CODE_LO: rd_byte = lo_w[ch_sel];
      `DTBCC_OFS_LOAD: rd_byte = load_q;
      `DTBCC_OFS_STATUS: rd_byte = {5'h00, srcv_w[ch_sel], code_w[ch_sel][9:8]};
      `DTBCC_OFS_PIN_IN: rd_byte = pin_rd;
      default: rd_hit = 1'b0;
    endcase
  end

  // Unmapped offsets read as zero and writes to them are dropped
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      AVS_READDATA <= 32'h00000000;
    end else if (acc_rd) begin
      AVS_READDATA <= rd_hit ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end
endmodule : dtbcc_top

// ==== dtbcc_top_tb.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module dtbcc_top_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [5:0] addr = 6'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata, got;
  logic waitreq;
  logic [39:0] code, icode;
  logic [3:0] en, a1, a2, d1, d2, i1, i2, sv;
  logic [7:0] pss, nss;
  int bad_count = 0;
  int n_checks = 0;
  dtbcc_top #(.NCH(4)) dtbcc_top_i (.CLK_SYS(clk), .SRST(srst), .CE(1'b1),
    .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .PIN_ONE_IN(4'hf), .PIN_TWO_IN(4'hf), .PIN_ONE_DIG_OE(4'hf), .PIN_TWO_DIG_OE(4'hf),
    .ACTIVE_CODE(code), .INTERNAL_CODE(icode), .CONVERTER_ENABLE(en),
    .ANALOG_OUT_PIN_ONE(a1), .ANALOG_OUT_PIN_TWO(a2), .PIN_ONE_DRIVE_OE(d1),
    .PIN_TWO_DRIVE_OE(d2), .PIN_ONE_INPUT_EN(i1), .PIN_TWO_INPUT_EN(i2),
    .POSITIVE_SOURCE_SELECT(pss), .NEGATIVE_SOURCE_SELECT(nss), .SOURCE_VALID(sv));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic end_sim;
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  // Holds the request until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (waitreq !== 1'b0) begin
      chk(40'h1, 40'h0, "bus timeout");
      end_sim();
    end
  endtask : bus
  task automatic chk_rd(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h0, 4'h0);
    chk({8'h0, got}, {8'h0, e}, "readback");
  endtask : chk_rd
  task automatic t_reset;
    for (int i = 0; i < 64; i += 16)
      for (int j = 0; j < 4; j++) chk_rd(6'(i + j), 32'h0);
    chk(code, 40'h0, "code after reset");
  endtask : t_reset
  task automatic t_right;
    bus(1'b1, 6'h01, 8'hff, 4'h1);
    bus(1'b1, 6'h02, 8'ha5, 4'h1);
    chk_rd(6'h01, 32'h3);
    chk_rd(6'h02, 32'ha5);
    chk(code, 40'h0, "code moved early");
    bus(1'b1, 6'h03, 8'h01, 4'h1);
    repeat (3) @(posedge clk);
    chk(code, 40'h3a5, "load one");
    chk_rd(6'h03, 32'h0);
  endtask : t_right
  task automatic t_left;
    bus(1'b1, 6'h10, 8'h40, 4'h1);
    bus(1'b1, 6'h11, 8'hc3, 4'h1);
    bus(1'b1, 6'h12, 8'hff, 4'h1);
    chk_rd(6'h12, 32'hc0);
    bus(1'b1, 6'h31, 8'hfe, 4'h1);
    bus(1'b1, 6'h32, 8'h01, 4'h1);
    bus(1'b1, 6'h21, 8'h01, 4'h1);
    bus(1'b1, 6'h22, 8'h00, 4'h1);
    chk_rd(6'h31, 32'h2);
    bus(1'b1, 6'h03, 8'h32, 4'h1);
    repeat (3) @(posedge clk);
    chk(code, {10'h201, 10'h100, 10'h30f, 10'h3a5}, "load many");
    chk(icode, code, "internal code");
  endtask : t_left
  task automatic t_ctrl;
    logic [9:0] t [7] = '{10'h0b0, 10'h024, 10'h08b, 10'h08c, 10'h082, 10'h28e, 10'h2d9};
    logic [7:0] c;
    logic v;
    int i;
    for (int k = 0; k < 7; k++) begin
      i = int'(t[k][9:8]);
      c = t[k][7:0];
      v = !((c[3:2] == 2'h3 && i < 2) || c[1:0] == 2'h3 || (c[1:0] == 2'h2 && i < 2));
      bus(1'b1, {t[k][9:8], 4'h0}, c, 4'h1);
      chk_rd({t[k][9:8], 4'h0}, {24'h0, c});
      repeat (2) @(posedge clk);
      chk({28'h0, en[i], a1[i], a2[i], d1[i], i1[i], d2[i], i2[i], sv[i], pss[2*i+:2],
           nss[2*i+:2]}, {28'h0, c[7], c[7] & c[5], c[7] & c[4], !c[5], !c[5], !c[4],
           !c[4], v, c[3:0]}, "control outputs");
      chk_rd({t[k][9:8], 4'h5}, {30'h0, !c[4], !c[5]});
    end
  endtask : t_ctrl
  task automatic t_refuse;
    bus(1'b1, 6'h00, 8'hff, 4'h0);
    chk_rd(6'h00, 32'h82);
    bus(1'b1, 6'h09, 8'hff, 4'h1);
    chk_rd(6'h09, 32'h0);
  endtask : t_refuse
  task automatic t_rst2;
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    chk_rd(6'h20, 32'h0);
    chk_rd(6'h11, 32'h0);
    chk({36'h0, en | a1 | a2}, 40'h0, "pins after reset");
    chk(code, 40'h0, "code after reset");
  endtask : t_rst2
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_right();
    t_left();
    t_ctrl();
    t_refuse();
    t_rst2();
    end_sim();
  end
endmodule : dtbcc_top_tb
